/* sifc_pkg.sv */
// Purpose: shared constants and types of the serial audio input port
// Assumes: one control register and one status register on a byte port
// Notes: format codes beyond right-justified 20 bits are captured as left-justified
package sifc_pkg;

	// register map
	localparam logic [11:0] SIFC_CTRL_ADDR = 12'h81F;
	localparam logic [11:0] SIFC_STATUS_ADDR = 12'h820;
	localparam logic [7:0] SIFC_CTRL_RESET = 8'h00;

	// control field positions
	localparam int SIFC_FMT_LSB = 0;
	localparam int SIFC_FMT_W = 3;
	localparam int SIFC_IBP_BIT = 3;
	localparam int SIFC_ILP_BIT = 4;
	localparam int SIFC_CTRL_W = 5;

	// status field positions
	localparam int SIFC_LOCKED_BIT = 0;

	// stream geometry
	localparam int SIFC_PIN_N = 4;
	localparam int SIFC_SAMPLE_W = 24;
	localparam int SIFC_RJ20_W = 20;
	localparam int SIFC_MSB_DELAY = 1;
	localparam int SIFC_TDM_SLOT_BITS = 32;
	localparam int SIFC_TDM_SLOTS = 8;

	// input data formats
	typedef enum logic [2:0] {
		SIFC_FMT_I2S = 3'h0,
		SIFC_FMT_LJ = 3'h1,
		SIFC_FMT_TDM = 3'h2,
		SIFC_FMT_RJ24 = 3'h3,
		SIFC_FMT_RJ20 = 3'h4
	} sifc_fmt_t;

	// control register layout, bit 4 down to bit 0
	typedef struct packed {
		logic input_frame_clock_polarity;
		logic input_bit_clock_polarity;
		sifc_fmt_t fmt;
	} sifc_ctrl_t;

	// one captured word: channel index and one sample per data pin
	typedef struct packed {
		logic [2:0] channel;
		logic [SIFC_PIN_N-1:0][SIFC_SAMPLE_W-1:0] data;
	} sifc_sample_t;

	// link framing states, gray along hunt -> stereo -> tdm
	typedef enum logic [1:0] {
		SIFC_ST_HUNT = 2'b00,
		SIFC_ST_STEREO = 2'b01,
		SIFC_ST_TDM = 2'b11
	} sifc_state_t;

endpackage

/* sifc_sync.sv */
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: each bit is a level or a slow toggle, not a bus word
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module sifc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sifc_sync_state_t;

	sifc_sync_state_t st;
	sifc_sync_state_t next_st;

	// first stage feeds only the second
	always_comb begin
		next_st = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;

endmodule
`default_nettype wire

/* sifc_serial_input.sv */
// Purpose: serial audio input port with format, frame and bit clock control
// Assumes: bit clock, frame clock and data all come from the audio source
// Notes: bit clock polarity is applied to the link clock itself, so change
//        it only while the link is quiet
//
// What this block does
// - polarity 0: left while frame clock low, right while high; 1 swaps
// - tdm frame starts after falling frame edge (polarity 0), rising (1)
// - pulse frame clock allowed; frame starts on its first edge
// - bit clock polarity picks data change edge; capture on the other edge
// - format field selects i2s, left, tdm or right-justified input
// - tdm slot msb arrives one bit clock after slot start
// - tdm frame has eight slots, channels 0-3 first half, 4-7 second
// - five-bit control resets to zero: frame pol, bit pol, format
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sifc_serial_input (
	// system clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// audio link from the source
	input wire logic bclk_i,
	input wire logic input_frame_clock_i,
	input wire logic [sifc_pkg::SIFC_PIN_N-1:0] serial_data_inputs_i,
	// captured samples
	output logic sample_valid_o,
	output sifc_pkg::sifc_sample_t sample_o
);

	localparam int SW = sifc_pkg::SIFC_SAMPLE_W;
	localparam int PN = sifc_pkg::SIFC_PIN_N;
	// stereo count of the last data bit, before adding the msb delay
	localparam logic [7:0] STEREO_LAST = 8'(SW - 1);
	// position in a tdm slot of the last bit of the sample
	localparam logic [4:0] TDM_LAST_POS =
		5'(sifc_pkg::SIFC_MSB_DELAY + SW - 1);
	localparam logic [7:0] CNT_SAT = 8'hFF;
	localparam int SLOT_LSB = $clog2(sifc_pkg::SIFC_TDM_SLOT_BITS);

	// state of the system clock domain
	typedef struct packed {
		sifc_pkg::sifc_ctrl_t ctrl;
		logic [7:0] rdata;
		logic tog_seen;
		logic valid;
		sifc_pkg::sifc_sample_t sample;
	} sifc_ref_state_t;

	// state of the link clock domain
	typedef struct packed {
		sifc_pkg::sifc_state_t st;
		logic prev_lr;
		logic [7:0] cnt;
		logic [PN-1:0][SW-1:0] sh;
		sifc_pkg::sifc_sample_t out;
		logic tog;
		logic locked;
		logic [3:0] cfg_prev;
		logic [3:0] cfg;
	} sifc_link_state_t;

	sifc_ref_state_t r;
	sifc_ref_state_t next_r;
	sifc_link_state_t l;
	sifc_link_state_t next_l;

	logic link_clk;
	logic [3:0] cfg_q;
	logic [1:0] back_q;
	logic [PN-1:0][SW-1:0] sh_in;
	sifc_pkg::sifc_fmt_t cfg_fmt;
	logic cfg_ilp;

	// invert the bit clock so capture lands opposite the data change edge
	assign link_clk = bclk_i ^ r.ctrl.input_bit_clock_polarity;

	// format and frame polarity into the link domain
	sifc_sync #(
		.W(4)
	) u_cfg_sync (
		.clk_i(link_clk),
		.rst_i(rst_i),
		.d_i({r.ctrl.input_frame_clock_polarity, r.ctrl.fmt}),
		.q_o(cfg_q)
	);

	// link logic uses the filtered copy, never a half-crossed word
	assign cfg_ilp = l.cfg[3];
	assign cfg_fmt = sifc_pkg::sifc_fmt_t'(l.cfg[2:0]);

	// lock level and sample toggle back into the system domain
	sifc_sync #(
		.W(2)
	) u_back_sync (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({l.locked, l.tog}),
		.q_o(back_q)
	);

	// per-pin shift of the newest data bit
	for (genvar p = 0; p < PN; p++) begin : g_shift
		assign sh_in[p] = {l.sh[p][SW-2:0], serial_data_inputs_i[p]};
	end

	// link framing, slot counting and sample capture
	always_comb begin
		logic lr;
		logic frame_edge;
		logic tdm_start;
		logic is_tdm;
		logic is_rj;
		logic emit;
		logic [7:0] cur_s;
		logic [7:0] cur_t;
		logic [7:0] last_s;
		lr = input_frame_clock_i;
		frame_edge = lr != l.prev_lr;
		// first edge of a pulse or square frame clock opens the frame
		tdm_start = frame_edge && (lr == cfg_ilp);
		is_tdm = cfg_fmt == sifc_pkg::SIFC_FMT_TDM;
		is_rj = (cfg_fmt == sifc_pkg::SIFC_FMT_RJ24) ||
			(cfg_fmt == sifc_pkg::SIFC_FMT_RJ20);
		last_s = (cfg_fmt == sifc_pkg::SIFC_FMT_I2S) ?
			8'(STEREO_LAST + 8'h01) : STEREO_LAST;
		cur_s = frame_edge ? 8'h00 :
			((l.cnt == CNT_SAT) ? l.cnt : 8'(l.cnt + 8'h01));
		cur_t = tdm_start ? 8'h00 : 8'(l.cnt + 8'h01);
		emit = 1'b0;
		next_l = l;
		next_l.prev_lr = lr;
		next_l.sh = sh_in;
		// bits may land on different edges, so a setting is taken only
		// once two synced samples agree
		next_l.cfg_prev = cfg_q;
		if (cfg_q == l.cfg_prev) begin
			next_l.cfg = cfg_q;
		end
		case (l.st)
			sifc_pkg::SIFC_ST_HUNT: begin
				next_l.locked = 1'b0;
				if (is_tdm && tdm_start) begin
					next_l.st = sifc_pkg::SIFC_ST_TDM;
					next_l.cnt = 8'h00;
				end else if (!is_tdm && frame_edge) begin
					next_l.st = sifc_pkg::SIFC_ST_STEREO;
					next_l.cnt = 8'h00;
				end
			end
			sifc_pkg::SIFC_ST_STEREO: begin
				if (is_tdm) begin
					next_l.st = sifc_pkg::SIFC_ST_HUNT;
				end else begin
					next_l.locked = 1'b1;
					next_l.cnt = cur_s;
					if (is_rj && frame_edge) begin
						// right-justified: the half just ended holds the lsbs
						emit = 1'b1;
						next_l.out.channel = {2'b00, l.prev_lr ^ cfg_ilp};
						for (int p = 0; p < PN; p++) begin
							if (cfg_fmt == sifc_pkg::SIFC_FMT_RJ20) begin
								next_l.out.data[p] = {
									l.sh[p][sifc_pkg::SIFC_RJ20_W-1:0],
									4'h0};
							end else begin
								next_l.out.data[p] = l.sh[p];
							end
						end
					end else if (!is_rj && cur_s == last_s) begin
						// i2s waits one bit for the msb, left-justified none
						emit = 1'b1;
						next_l.out.channel = {2'b00, lr ^ cfg_ilp};
						next_l.out.data = sh_in;
					end
				end
			end
			sifc_pkg::SIFC_ST_TDM: begin
				if (!is_tdm) begin
					next_l.st = sifc_pkg::SIFC_ST_HUNT;
				end else begin
					next_l.locked = 1'b1;
					// trailing pulse edge does not restart the count
					next_l.cnt = cur_t;
					if (cur_t[SLOT_LSB-1:0] == TDM_LAST_POS) begin
						emit = 1'b1;
						// slot number is the channel, 0-3 then 4-7
						next_l.out.channel = cur_t[7:SLOT_LSB];
						next_l.out.data = '0;
						next_l.out.data[0] = sh_in[0];
					end
				end
			end
			default: begin
				next_l.st = sifc_pkg::SIFC_ST_HUNT;
			end
		endcase
		if (emit) begin
			next_l.tog = ~l.tog;
		end
	end

	// link state register
	always_ff @(posedge link_clk or posedge rst_i) begin
		if (rst_i) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// register access and sample hand-over in the system domain
	always_comb begin
		next_r = r;
		next_r.valid = 1'b0;
		next_r.rdata = 8'h00;
		if (reg_wr_i && reg_addr_i == sifc_pkg::SIFC_CTRL_ADDR) begin
			// upper bits of the write are dropped
			next_r.ctrl = reg_wdata_i[sifc_pkg::SIFC_CTRL_W-1:0];
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				sifc_pkg::SIFC_CTRL_ADDR: begin
					next_r.rdata = {3'b000, r.ctrl};
				end
				sifc_pkg::SIFC_STATUS_ADDR: begin
					next_r.rdata = 8'h00;
					next_r.rdata[sifc_pkg::SIFC_LOCKED_BIT] = back_q[1];
				end
				default: begin
					next_r.rdata = 8'h00;
				end
			endcase
		end
		// link word is stable for a whole slot after its toggle
		if (back_q[0] != r.tog_seen) begin
			next_r.tog_seen = back_q[0];
			next_r.valid = 1'b1;
			next_r.sample = l.out;
		end
	end

	// system state register, control resets to its default
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.ctrl <= sifc_pkg::SIFC_CTRL_RESET[sifc_pkg::SIFC_CTRL_W-1:0];
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata_o = r.rdata;
	assign sample_valid_o = r.valid;
	assign sample_o = r.sample;

endmodule
`default_nettype wire

/* sifc_serial_input_checker.sv */
// Purpose: port checker for the serial input block
// Assumes: sees the top ports only
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sifc_serial_input_checker (
	// clock and register port
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// captured samples
	input wire logic sample_valid_o,
	input wire sifc_pkg::sifc_sample_t sample_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// register port
	a_rd_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
	a_rd_upper: assert property (
		reg_rd_i |=> reg_rdata_o[7:5] == 3'h0) else $error("upper bits set");
	a_unmapped: assert property (
		reg_rd_i && reg_addr_i != sifc_pkg::SIFC_CTRL_ADDR
		&& reg_addr_i != sifc_pkg::SIFC_STATUS_ADDR |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_echo: assert property (
		(reg_wr_i && reg_addr_i == sifc_pkg::SIFC_CTRL_ADDR) ##1
		(reg_rd_i && reg_addr_i == sifc_pkg::SIFC_CTRL_ADDR)
		|=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h1F))
		else $error("control readback wrong");
	a_status: assert property (
		reg_rd_i && reg_addr_i == sifc_pkg::SIFC_STATUS_ADDR
		|=> reg_rdata_o[7:1] == 7'h00) else $error("status upper bits set");
	// captured samples
	a_valid_pulse: assert property (
		sample_valid_o |=> !sample_valid_o [*8]) else $error("valid too long");
	a_sample_hold: assert property (
		!sample_valid_o |-> $stable(sample_o)) else $error("sample moved");
	a_tdm_lanes: assert property (
		sample_valid_o && sample_o.channel > 3'h1
		|-> sample_o.data[3:1] == 72'h0) else $error("tdm lane not zero");
endmodule
bind sifc_serial_input sifc_serial_input_checker u_chk (.ref_clk_i, .rst_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.sample_valid_o, .sample_o);
`default_nettype wire

/* sifc_src_model.sv */
// Purpose: audio source driving the serial input link
// Assumes: 32 ns bit clock, running inside frames and during idle between them
// Notes: unused data bits toggle every bit so stale values never match
`timescale 1ns/1ps
`default_nettype none
module sifc_src_model (
	// link to the block
	output logic bclk_o,
	output logic frame_o,
	output logic [3:0] sdata_o
);
	logic [23:0] word [8][4];
	// idle levels
	initial begin
		bclk_o = 1'b1;
		frame_o = 1'b1;
		sdata_o = 4'h0;
	end
	// one frame of n bits: stereo halves or a tdm pulse frame
	task automatic send(input sifc_pkg::sifc_fmt_t f, input logic input_frame_clock_polarity, input_bit_clock_polarity,
		input int n);
		bit tdm;
		int d;
		int w;
		int b;
		tdm = f == sifc_pkg::SIFC_FMT_TDM;
		d = f == sifc_pkg::SIFC_FMT_LJ ? 0 : f == sifc_pkg::SIFC_FMT_RJ24 ? 8 :
			f == sifc_pkg::SIFC_FMT_RJ20 ? 12 : 1;
		w = f == sifc_pkg::SIFC_FMT_RJ20 ? 20 : 24;
		#(0.1 * $urandom_range(1, 79));
		frame_o = !input_frame_clock_polarity;
		bclk_o = !input_bit_clock_polarity;
		#16;
		for (int i = 0; i < n; i++) begin
			bclk_o = input_bit_clock_polarity; // change edge
			frame_o = tdm ? input_frame_clock_polarity ^ (i != 0) : input_frame_clock_polarity ^ i[5];
			b = i % 32 - d;
			for (int p = 0; p < 4; p++) begin
				sdata_o[p] = b >= 0 && b < w && (p == 0 || !tdm) ?
					word[i / 32][p][23 - b] : !sdata_o[p];
			end
			#16;
			bclk_o = !input_bit_clock_polarity;
			#16;
		end
	endtask
	// quiet bit clocks with a steady frame clock, lets a new setting settle
	task automatic idle(input logic input_frame_clock_polarity, input_bit_clock_polarity, input int n);
		frame_o = !input_frame_clock_polarity;
		bclk_o = !input_bit_clock_polarity;
		for (int i = 0; i < n; i++) begin
			#16;
			bclk_o = input_bit_clock_polarity;
			#16;
			bclk_o = !input_bit_clock_polarity; // capture edge
		end
	endtask
endmodule
`default_nettype wire

/* serial_input_format_control_tb_top.sv */
// Purpose: self-checking bench for the serial input block
// Assumes: source model drives the link, bench drives registers
// Notes: frames repeat the same words, so every word captured after the first frame is checked
`timescale 1ns/1ps
`default_nettype none
module serial_input_format_control_tb_top;
	logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, sample_valid_o, bclk, frame;
	logic on, tdm;
	logic [11:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [3:0] sdata;
	logic [23:0] mask;
	logic [95:0] e;
	logic [4:0] cfgs [6] = '{5'h00, 5'h11, 5'h1B, 5'h14, 5'h12, 5'h0A};
	sifc_pkg::sifc_sample_t sample_o;
	sifc_pkg::sifc_ctrl_t c;
	int got, checked, err_total;
	sifc_serial_input u_sifc_serial_input (.ref_clk_i, .rst_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bclk_i(bclk),
		.input_frame_clock_i(frame), .serial_data_inputs_i(sdata),
		.sample_valid_o, .sample_o);
	sifc_src_model u_sifc_src_model (.bclk_o(bclk), .frame_o(frame),
		.sdata_o(sdata));
	// system clock
	always #4 ref_clk_i = !ref_clk_i;
	// compare and count
	task automatic chk(input string n, input logic [95:0] s, x);
		checked++;
		if (s !== x) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", n, x, s);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// register write, one strobe cycle
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// register read, data checked in the following cycle
	task automatic rd(input logic [11:0] a, input logic [7:0] x, m);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("rdata", reg_rdata_o & m, x);
		@(posedge ref_clk_i);
	endtask
	// each word captured while on against the source words of its channel, tdm lanes 1-3 against zero,
	// looked at mid-cycle while the registered outputs are settled
	always @(negedge ref_clk_i) begin
		if (on && sample_valid_o === 1'b1) begin
			got++;
			for (int p = 0; p < 4; p++)
				e[p*24 +: 24] = tdm && p > 0 ? 24'h0 :
					u_sifc_src_model.word[sample_o.channel][p] & mask;
			chk("sample", sample_o.data, e);
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'hB3528A94));
		{ref_clk_i, reg_wr_i, reg_rd_i, on, tdm} = 5'h00;
		rst_i = 1'b1;
		reg_addr_i = 12'h000;
		reg_wdata_i = 8'h00;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd(12'h81F, 8'h00, 8'hFF);
		rd(12'h821, 8'h00, 8'hFF);
		rd(12'h820, 8'h00, 8'hFE);
		foreach (cfgs[k]) begin
			c = cfgs[k];
			wr(12'h81F, {3'($urandom), cfgs[k]});
			rd(12'h81F, {3'h0, cfgs[k]}, 8'hFF);
			for (int s = 0; s < 8; s++)
				for (int p = 0; p < 4; p++)
					u_sifc_src_model.word[s][p] = 24'($urandom);
			tdm = c.fmt == sifc_pkg::SIFC_FMT_TDM;
			mask = c.fmt == sifc_pkg::SIFC_FMT_RJ20 ? 24'hFFFFF0 : 24'hFFFFFF;
			got = 0;
			// settle the link on the new setting; first frame is not checked
			u_sifc_src_model.idle(c.input_frame_clock_polarity, c.input_bit_clock_polarity, 6);
			u_sifc_src_model.send(c.fmt, c.input_frame_clock_polarity, c.input_bit_clock_polarity, tdm ? 256 : 64);
			on <= 1'b1;
			u_sifc_src_model.send(c.fmt, c.input_frame_clock_polarity, c.input_bit_clock_polarity, tdm ? 256 : 64);
			u_sifc_src_model.send(c.fmt, c.input_frame_clock_polarity, c.input_bit_clock_polarity, 4);
			repeat (12) @(posedge ref_clk_i);
			on <= 1'b0;
			chk("count", got >= (tdm ? 8 : 2), 1);
		end
		summarize();
	end
	// watchdog for a stuck run
	initial begin
		#200us;
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
